// >>> core/gpm_pkg.sv
// Shared constants and carrier types for the pin function mux and input qualifier
package gpm_pkg;

   // Port geometry
   localparam int NUM_PINS = 35;
   localparam int GRP_SIZE = 8;
   localparam int NUM_GRP = 5;
   localparam int NUM_SH = 5;
   localparam int NUM_ENT = 14;

   // Register byte offsets on the bus
   localparam logic [11:0] OFS_FSEL_A_LO = 12'h000;
   localparam logic [11:0] OFS_FSEL_A_HI = 12'h004;
   localparam logic [11:0] OFS_FSEL_B = 12'h008;
   localparam logic [11:0] OFS_QSEL_A_LO = 12'h00c;
   localparam logic [11:0] OFS_QSEL_A_HI = 12'h010;
   localparam logic [11:0] OFS_QSEL_B = 12'h014;
   localparam logic [11:0] OFS_CTRL_A = 12'h018;
   localparam logic [11:0] OFS_CTRL_B = 12'h01c;
   localparam logic [11:0] OFS_STAT_A = 12'h020;
   localparam logic [11:0] OFS_STAT_B = 12'h024;

   // Values after reset: plain I/O, sync only, sample every cycle
   localparam logic [31:0] FSEL_RST = 32'h00000000;
   localparam logic [31:0] QSEL_RST = 32'h00000000;
   localparam logic [31:0] CTRL_RST = 32'h00000000;

   // Implemented bits of the port B registers (pins 32 to 34, one group)
   localparam logic [31:0] SEL_B_MASK = 32'h0000003f;
   localparam logic [31:0] CTRL_B_MASK = 32'h000000ff;

   // Period field: 8 bits per group of eight pins
   localparam int PRD_W = 8;
   localparam int CNT_W = 9;

   // Function select codes
   localparam logic [1:0] FS_GPIO = 2'h0;

   // Qualifier mode codes
   localparam logic [1:0] QM_SYNC = 2'h0;
   localparam logic [1:0] QM_WIN3 = 2'h1;
   localparam logic [1:0] QM_WIN6 = 2'h2;
   localparam logic [1:0] QM_ASYNC = 2'h3;

   // Shared peripheral inputs fed from several pins, grouped by input, each input's pins listed by rising pin number
   // Index 0 CAN-B receive, 1 UART-B receive, 2 PWM sync in, 3 trip 5, 4 trip 6
   localparam logic [5:0] SH_PIN [NUM_ENT] = '{6'h0a, 6'h0d, 6'h11, 6'h15,
      6'h0b, 6'h0f, 6'h13, 6'h17, 6'h06, 6'h20, 6'h10, 6'h1c, 6'h11, 6'h1d};
   localparam logic [1:0] SH_SEL [NUM_ENT] = '{2'h2, 2'h2, 2'h2, 2'h3,
      2'h2, 2'h2, 2'h2, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
   localparam logic [2:0] SH_IDX [NUM_ENT] = '{3'h0, 3'h0, 3'h0, 3'h0,
      3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
   // Idle levels: receivers and active-low trips idle high, sync idles low
   localparam logic [NUM_SH-1:0] SH_IDLE = 5'h1b;

   // APB request and answer
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } gpm_apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } gpm_apb_rsp_s;

endpackage

// >>> core/gpm_qual.sv
// Per-pin input synchroniser and sampling-window qualifier
`timescale 1ns/1ps
module gpm_qual (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic [1:0] mode_in,
   input wire logic sample_en_in,
   output logic qual_out
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic [5:0] hist;
      logic q;
   } gpm_qual_s;

   gpm_qual_s r;
   gpm_qual_s next_r;
   logic [5:0] nh;

   // Window shifts on the group's sample pulse only
   always_comb begin
      next_r = r;
      nh = {r.hist[4:0], r.s2};
      next_r.s1 = pin_in;
      next_r.s2 = r.s1;
      if (sample_en_in) begin
         next_r.hist = nh;
         if (mode_in == gpm_pkg::QM_WIN3 && (nh[2:0] == 3'h0 || nh[2:0] == 3'h7)) begin
            next_r.q = nh[0];
         end
         if (mode_in == gpm_pkg::QM_WIN6 && (nh == 6'h00 || nh == 6'h3f)) begin
            next_r.q = nh[0];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // Async mode bypasses the flops; the peripheral resynchronises it
   always_comb begin
      unique case (mode_in)
         gpm_pkg::QM_SYNC: qual_out = r.s2;
         gpm_pkg::QM_ASYNC: qual_out = pin_in;
         default: qual_out = r.q;
      endcase
   end

   chk_sync_two_flops: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $past(rst_n_in, 2) && mode_in == gpm_pkg::QM_SYNC |-> qual_out == $past(pin_in, 2))
      else $error("sync-only output is not the pin two clocks back");
   chk_win3_agree: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $past(mode_in) == gpm_pkg::QM_WIN3 && r.q != $past(r.q) |-> r.hist[2:0] == {3{r.q}})
      else $error("three-sample output changed without agreement");
   chk_win6_agree: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      $past(mode_in) == gpm_pkg::QM_WIN6 && r.q != $past(r.q) |-> r.hist == {6{r.q}})
      else $error("six-sample output changed without agreement");
   chk_async_pass: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_in == gpm_pkg::QM_ASYNC |-> qual_out == pin_in)
      else $error("async mode does not pass the pin through");
   cov_win6_change: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      mode_in == gpm_pkg::QM_WIN6 && $changed(r.q));

endmodule

// >>> core/gpm_mux.sv
// Pin function multiplexer with APB registers and per-group sample dividers
//
// Contract
// - Pin select fields come from port A low, port A high, port B registers.
// - Reserved selections attach nothing; pin level undefined, may be driven.
// - Every pin has its own two-bit qualifier mode register field.
// - Mode 00 is reset default and only synchronises the input.
// - Modes 01 and 10 qualify the synchronised input over a sample window.
// - Sample interval is a programmable multiple of system clocks.
// - Each group of eight pins shares one sample period field.
// - The window is three or six samples wide by mode.
// - Output changes only when all window samples agree.
// - Mode 11 passes the pin unsynchronised to the peripheral.
// - A shared peripheral input selects among all pins routing it.
// - A shared input with no pin selecting it sits at its idle level.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module gpm_mux (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire gpm_pkg::gpm_apb_req_s apb_in,
   output gpm_pkg::gpm_apb_rsp_s apb_out,
   input wire logic [gpm_pkg::NUM_PINS-1:0] pin_in,
   output logic [gpm_pkg::NUM_PINS-1:0] pin_out,
   output logic [gpm_pkg::NUM_PINS-1:0] pin_oe_out,
   input wire logic [gpm_pkg::NUM_PINS-1:0] gpio_out_in,
   input wire logic [gpm_pkg::NUM_PINS-1:0] gpio_oe_in,
   output logic [gpm_pkg::NUM_PINS-1:0] gpio_in_out,
   input wire logic [gpm_pkg::NUM_PINS-1:0][2:0] periph_out_in,
   input wire logic [gpm_pkg::NUM_PINS-1:0][2:0] periph_oe_in,
   output logic [gpm_pkg::NUM_PINS-1:0][2:0] periph_in_out,
   output logic [gpm_pkg::NUM_SH-1:0] shared_in_out
);

   typedef struct packed {
      logic [31:0] fsel_a_lo;
      logic [31:0] fsel_a_hi;
      logic [31:0] fsel_b;
      logic [31:0] qsel_a_lo;
      logic [31:0] qsel_a_hi;
      logic [31:0] qsel_b;
      logic [31:0] ctrl_a;
      logic [31:0] ctrl_b;
      logic [31:0] rdata;
      logic slverr;
      logic [gpm_pkg::NUM_GRP-1:0][gpm_pkg::CNT_W-1:0] cnt;
   } gpm_regs_s;

   gpm_regs_s r;
   gpm_regs_s next_r;

   logic [2*gpm_pkg::NUM_PINS-1:0] fsel_all;
   logic [2*gpm_pkg::NUM_PINS-1:0] qsel_all;
   logic [gpm_pkg::NUM_GRP*gpm_pkg::PRD_W-1:0] prd_all;
   logic [gpm_pkg::NUM_GRP-1:0] sample_en;
   logic [gpm_pkg::NUM_PINS-1:0] qual;
   logic setup;
   logic access;

   // Byte-lane merge for APB writes
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Flatten select fields so pin i owns bits 2i+1:2i
   assign fsel_all = {r.fsel_b[5:0], r.fsel_a_hi, r.fsel_a_lo};
   assign qsel_all = {r.qsel_b[5:0], r.qsel_a_hi, r.qsel_a_lo};
   assign prd_all = {r.ctrl_b[7:0], r.ctrl_a};

   assign setup = apb_in.psel && !apb_in.penable;
   assign access = apb_in.psel && apb_in.penable;

   // Zero-wait access phase; read data was captured during setup
   assign apb_out.pready = access;
   assign apb_out.prdata = r.rdata;
   assign apb_out.pslverr = access && r.slverr;

   // Register file, read capture and sample dividers
   always_comb begin
      next_r = r;
      if (setup) begin
         next_r.slverr = 1'b0;
         unique case (apb_in.paddr)
            gpm_pkg::OFS_FSEL_A_LO: next_r.rdata = r.fsel_a_lo;
            gpm_pkg::OFS_FSEL_A_HI: next_r.rdata = r.fsel_a_hi;
            gpm_pkg::OFS_FSEL_B: next_r.rdata = r.fsel_b;
            gpm_pkg::OFS_QSEL_A_LO: next_r.rdata = r.qsel_a_lo;
            gpm_pkg::OFS_QSEL_A_HI: next_r.rdata = r.qsel_a_hi;
            gpm_pkg::OFS_QSEL_B: next_r.rdata = r.qsel_b;
            gpm_pkg::OFS_CTRL_A: next_r.rdata = r.ctrl_a;
            gpm_pkg::OFS_CTRL_B: next_r.rdata = r.ctrl_b;
            gpm_pkg::OFS_STAT_A: next_r.rdata = gpio_in_out[31:0];
            gpm_pkg::OFS_STAT_B: next_r.rdata = {29'h0, gpio_in_out[34:32]};
            default: begin
               next_r.rdata = 32'h0;
               next_r.slverr = 1'b1;
            end
         endcase
      end
      // Write lands at the completing access edge; address held since setup
      if (access && apb_in.pwrite && !r.slverr) begin
         unique case (apb_in.paddr)
            gpm_pkg::OFS_FSEL_A_LO: next_r.fsel_a_lo = wmerge(r.fsel_a_lo, apb_in.pwdata,
                                                               apb_in.pstrb);
            gpm_pkg::OFS_FSEL_A_HI: next_r.fsel_a_hi = wmerge(r.fsel_a_hi, apb_in.pwdata,
                                                               apb_in.pstrb);
            gpm_pkg::OFS_FSEL_B: next_r.fsel_b = wmerge(r.fsel_b, apb_in.pwdata,
                                                         apb_in.pstrb) & gpm_pkg::SEL_B_MASK;
            gpm_pkg::OFS_QSEL_A_LO: next_r.qsel_a_lo = wmerge(r.qsel_a_lo, apb_in.pwdata,
                                                               apb_in.pstrb);
            gpm_pkg::OFS_QSEL_A_HI: next_r.qsel_a_hi = wmerge(r.qsel_a_hi, apb_in.pwdata,
                                                               apb_in.pstrb);
            gpm_pkg::OFS_QSEL_B: next_r.qsel_b = wmerge(r.qsel_b, apb_in.pwdata,
                                                         apb_in.pstrb) & gpm_pkg::SEL_B_MASK;
            gpm_pkg::OFS_CTRL_A: next_r.ctrl_a = wmerge(r.ctrl_a, apb_in.pwdata,
                                                         apb_in.pstrb);
            gpm_pkg::OFS_CTRL_B: next_r.ctrl_b = wmerge(r.ctrl_b, apb_in.pwdata,
                                                         apb_in.pstrb) & gpm_pkg::CTRL_B_MASK;
            default: next_r.rdata = r.rdata; // Status words are read-only
         endcase
      end
      // Interval is 2*period clocks, period 0 samples every clock
      for (int g = 0; g < gpm_pkg::NUM_GRP; g++) begin
         if (r.cnt[g] == '0) begin
            next_r.cnt[g] = (prd_all[g*gpm_pkg::PRD_W +: gpm_pkg::PRD_W] == '0) ? '0 :
               {prd_all[g*gpm_pkg::PRD_W +: gpm_pkg::PRD_W], 1'b0} - 9'h001;
         end else begin
            next_r.cnt[g] = r.cnt[g] - 9'h001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         r.fsel_a_lo <= gpm_pkg::FSEL_RST;
         r.fsel_a_hi <= gpm_pkg::FSEL_RST;
         r.fsel_b <= gpm_pkg::FSEL_RST;
         r.qsel_a_lo <= gpm_pkg::QSEL_RST;
         r.qsel_a_hi <= gpm_pkg::QSEL_RST;
         r.qsel_b <= gpm_pkg::QSEL_RST;
         r.ctrl_a <= gpm_pkg::CTRL_RST;
         r.ctrl_b <= gpm_pkg::CTRL_RST;
         r.rdata <= 32'h0;
         r.slverr <= 1'b0;
         r.cnt <= '0;
      end else begin
         r <= next_r;
      end
   end

   // One sample pulse per group of eight pins
   generate
      for (genvar g = 0; g < gpm_pkg::NUM_GRP; g++) begin : g_grp
         assign sample_en[g] = (r.cnt[g] == '0);
      end
   endgenerate

   // Per-pin routing and qualification
   generate
      for (genvar i = 0; i < gpm_pkg::NUM_PINS; i++) begin : g_pin
         logic [1:0] fs;
         assign fs = fsel_all[2*i +: 2];
         // Reserved selections just follow their tied peripheral port
         always_comb begin
            if (fs == gpm_pkg::FS_GPIO) begin
               pin_out[i] = gpio_out_in[i];
               pin_oe_out[i] = gpio_oe_in[i];
            end else begin
               pin_out[i] = periph_out_in[i][fs - 2'h1];
               pin_oe_out[i] = periph_oe_in[i][fs - 2'h1];
            end
         end
         gpm_qual u_qual (
            .clk_in(clk_in),
            .rst_n_in(rst_n_in),
            .pin_in(pin_in[i]),
            .mode_in(qsel_all[2*i +: 2]),
            .sample_en_in(sample_en[i / gpm_pkg::GRP_SIZE]),
            .qual_out(qual[i])
         );
         assign gpio_in_out[i] = qual[i];
         // Unselected private peripheral inputs read low
         assign periph_in_out[i][0] = qual[i] && fs == 2'h1;
         assign periph_in_out[i][1] = qual[i] && fs == 2'h2;
         assign periph_in_out[i][2] = qual[i] && fs == 2'h3;
      end
   endgenerate

   // Shared inputs: lowest pin wins when several pins route the same signal
   always_comb begin
      shared_in_out = gpm_pkg::SH_IDLE;
      for (int e = gpm_pkg::NUM_ENT - 1; e >= 0; e--) begin
         if (fsel_all[2*gpm_pkg::SH_PIN[e] +: 2] == gpm_pkg::SH_SEL[e]) begin
            shared_in_out[gpm_pkg::SH_IDX[e]] = qual[gpm_pkg::SH_PIN[e]];
         end
      end
   end

   chk_fsel_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      access && apb_in.pwrite && apb_in.paddr == gpm_pkg::OFS_FSEL_A_HI && !r.slverr &&
      apb_in.pstrb == 4'hf |=> r.fsel_a_hi == $past(apb_in.pwdata))
      else $error("high function select word not written");
   chk_route_sel1: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      fsel_all[25:24] == 2'h1 |-> pin_out[12] == periph_out_in[12][0]
      && pin_oe_out[12] == periph_oe_in[12][0])
      else $error("pin 12 not routed to selection 1");
   chk_route_gpio: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      fsel_all[69:68] == 2'h0 |-> pin_out[34] == gpio_out_in[34])
      else $error("pin 34 not on plain I/O");
   chk_qsel_reset: assert property (@(posedge clk_in)
      !rst_n_in |=> qsel_all == '0 && fsel_all == '0)
      else $error("selects not cleared by reset");
   chk_period_gap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      sample_en[0] && r.ctrl_a[7:0] == 8'h02 |=> !sample_en[0] [*3] ##1 sample_en[0])
      else $error("group 0 sample interval wrong");
   chk_shared_pick: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      fsel_all[21:20] == 2'h2 |-> shared_in_out[0] == qual[10])
      else $error("pin 10 does not feed shared receive input");
   chk_shared_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      fsel_all[13:12] != 2'h2 && fsel_all[65:64] != 2'h2 |-> shared_in_out[2] == 1'b0)
      else $error("unselected sync input not idle");
   chk_unmapped_err: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      setup && apb_in.paddr == 12'h028 |=> apb_out.pslverr && apb_out.prdata == 32'h0)
      else $error("unmapped address not refused");
   cov_apb_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      access && !apb_in.pwrite && apb_in.paddr == gpm_pkg::OFS_STAT_A);
   cov_shared_route: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      fsel_all[35:34] == 2'h2 && fsel_all[21:20] != 2'h2);
   cov_win_mode: cover property (@(posedge clk_in) disable iff (!rst_n_in)
      qsel_all[1:0] == gpm_pkg::QM_WIN6 && r.ctrl_a[7:0] != 8'h00);

endmodule

// >>> tb/gpm_pad_model.sv
// Pad model: external drivers and pull-ups resolved against the device drive
`timescale 1ns/1ps
module gpm_pad_model (
   input wire logic [gpm_pkg::NUM_PINS-1:0] pin_out_in,
   input wire logic [gpm_pkg::NUM_PINS-1:0] pin_oe_in,
   input wire logic [gpm_pkg::NUM_PINS-1:0] ext_lvl_in,
   input wire logic [gpm_pkg::NUM_PINS-1:0] ext_en_in,
   output logic [gpm_pkg::NUM_PINS-1:0] pad_out
);
   // Device drive wins; a pad nobody drives floats up to its pull-up
   assign pad_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in & ext_lvl_in)
      | (~pin_oe_in & ~ext_en_in);
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the pin function mux and input qualifier
`timescale 1ns/1ps
module testbench;
   localparam int N = gpm_pkg::NUM_PINS;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   gpm_pkg::gpm_apb_req_s apb_req = '0;
   gpm_pkg::gpm_apb_rsp_s apb_rsp;
   logic [N-1:0] pin_in, pin_out, pin_oe, gpio_in, exp_o, exp_e;
   logic [N-1:0] gpio_out = 35'h2aaaa5555;
   logic [N-1:0] gpio_oe = 35'h13c3cc3c3;
   logic [N-1:0] ext_lvl = '0;
   logic [N-1:0] ext_en = '1;
   logic [N-1:0][2:0] per_out, per_oe, per_in, exp3;
   logic [4:0] shared;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   int lat_tab [4] = '{2, 5, 8, 0};

   gpm_mux i_gpm_mux (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .apb_in(apb_req),
      .apb_out(apb_rsp),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .pin_oe_out(pin_oe),
      .gpio_out_in(gpio_out),
      .gpio_oe_in(gpio_oe),
      .gpio_in_out(gpio_in),
      .periph_out_in(per_out),
      .periph_oe_in(per_oe),
      .periph_in_out(per_in),
      .shared_in_out(shared)
   );

   gpm_pad_model i_gpm_pad_model (
      .pin_out_in(pin_out),
      .pin_oe_in(pin_oe),
      .ext_lvl_in(ext_lvl),
      .ext_en_in(ext_en),
      .pad_out(pin_in)
   );

   always #10 clk_in = ~clk_in;

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   task automatic summarize();
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; waits on pready rather than assuming a latency
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         input logic [3:0] s, output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge clk_in);
      apb_req.psel <= 1'b1;
      apb_req.penable <= 1'b0;
      apb_req.pwrite <= w;
      apb_req.paddr <= a;
      apb_req.pwdata <= d;
      apb_req.pstrb <= s;
      @(posedge clk_in);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      r = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, s, r, e);
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] r, output logic e);
      apb(1'b0, a, 32'h0, 4'h0, r, e);
   endtask

   // Waits edges, then lets their updates land before anything is sampled
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_in);
      #1;
   endtask

   task automatic set_pin(input int p, input logic v);
      @(posedge clk_in);
      ext_lvl[p] <= v;
   endtask

   // Edges from a pad change until the qualified input follows it
   task automatic measure(input int p, input logic v, output int n);
      set_pin(p, v);
      n = 0;
      #1;
      while (gpio_in[p] !== v && n < 100) begin
         @(posedge clk_in);
         #1;
         n++;
      end
   endtask

   initial begin
      logic [31:0] r;
      logic e;
      int lat;
      logic [1:0] s;
      for (int i = 0; i < N; i++) begin
         for (int k = 0; k < 3; k++) begin
            per_out[i][k] = 1'((i + k) % 2);
            per_oe[i][k] = 1'(((i >> 1) + k) % 2);
         end
      end
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // Reset values, read-back with port B masks, then an unmapped hole
      for (int a = 0; a < 8; a++) begin
         rd(12'(a * 4), r, e);
         check({e, r}, 33'h0);
         wr(12'(a * 4), 32'hffffffff, 4'hf);
         rd(12'(a * 4), r, e);
         check(r, (a % 3 == 2) ? 32'h3f : (a == 7) ? 32'hff : 32'hffffffff);
         wr(12'(a * 4), 32'h0, 4'hf);
      end
      rd(12'h028, r, e);
      check({e, r}, {1'b1, 32'h0});
      wr(gpm_pkg::OFS_CTRL_A, 32'hffffffff, 4'h2);
      rd(gpm_pkg::OFS_CTRL_A, r, e);
      check(r, 32'h0000ff00);
      // Mid-run reset; also flushes the long divider counts loaded above
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(gpm_pkg::OFS_CTRL_A, r, e);
      check(r, gpm_pkg::CTRL_RST);
      wr(gpm_pkg::OFS_CTRL_A, 32'h0, 4'hf);
      // Every select code on every pin; ends back on plain I/O
      for (int v = 3; v >= 0; v--) begin
         s = 2'(v);
         wr(gpm_pkg::OFS_FSEL_A_LO, {16{s}}, 4'hf);
         wr(gpm_pkg::OFS_FSEL_A_HI, {16{s}}, 4'hf);
         wr(gpm_pkg::OFS_FSEL_B, {16{s}}, 4'hf);
         cyc(4);
         for (int i = 0; i < N; i++) begin
            exp_o[i] = (s == 2'h0) ? gpio_out[i] : per_out[i][s - 2'h1];
            exp_e[i] = (s == 2'h0) ? gpio_oe[i] : per_oe[i][s - 2'h1];
            for (int k = 0; k < 3; k++) begin
               exp3[i][k] = (s == 2'(k + 1)) & pin_in[i];
            end
         end
         check({pin_out, pin_oe}, {exp_o, exp_e});
         check(per_in, exp3);
         check(gpio_in, pin_in);
         rd(gpm_pkg::OFS_STAT_A, r, e);
         check(r, pin_in[31:0]);
         rd(gpm_pkg::OFS_STAT_B, r, e);
         check(r, {29'h0, pin_in[34:32]});
      end
      // Shared receive input fed from pins 10 and 21
      @(posedge clk_in);
      gpio_oe <= '0;
      per_oe <= '0;
      cyc(4);
      check(shared, gpm_pkg::SH_IDLE);
      wr(gpm_pkg::OFS_FSEL_A_LO, 32'h00200000, 4'hf);
      wr(gpm_pkg::OFS_FSEL_A_HI, 32'h00000c00, 4'hf);
      set_pin(21, 1'b1);
      cyc(4);
      check(shared[0], 1'b0);
      set_pin(10, 1'b1);
      set_pin(21, 1'b0);
      cyc(4);
      check(shared[0], 1'b1);
      wr(gpm_pkg::OFS_FSEL_A_LO, 32'h0, 4'hf);
      cyc(4);
      check(shared[0], 1'b0);
      wr(gpm_pkg::OFS_FSEL_A_HI, 32'h0, 4'hf);
      cyc(1);
      check(shared, gpm_pkg::SH_IDLE);
      // Latency per qualifier mode, and a pulse one sample short of the window
      for (int v = 0; v < 4; v++) begin
         wr(gpm_pkg::OFS_QSEL_A_LO, 32'(v), 4'hf);
         set_pin(0, 1'b0);
         cyc(20);
         measure(0, 1'b1, lat);
         check(lat, lat_tab[v]);
         measure(0, 1'b0, lat);
         check(lat, lat_tab[v]);
         if (v == 1 || v == 2) begin
            e = 1'b0;
            set_pin(0, 1'b1);
            cyc(lat_tab[v] - 4);
            set_pin(0, 1'b0);
            repeat (12) begin
               @(posedge clk_in);
               #1;
               e = e | gpio_in[0];
            end
            check(e, 1'b0);
         end
      end
      // Group 0 samples every 4 clocks, group 1 every clock
      wr(gpm_pkg::OFS_CTRL_A, 32'h00000002, 4'hf);
      wr(gpm_pkg::OFS_QSEL_A_LO, 32'h00010001, 4'hf);
      cyc(40);
      measure(0, 1'b1, lat);
      check(lat >= 11 && lat <= 14, 1'b1);
      measure(8, 1'b1, lat);
      check(lat, 5);
      summarize();
   end
endmodule
